//--- shared/sauf_pkg.sv
`default_nettype none
package sauf_pkg;
	localparam int unsigned ADDR_W     = 8;
	localparam int unsigned DATA_W     = 32;
	localparam int unsigned ADDR_BYTES = 6;
	localparam int unsigned CNT_W      = 16;

	// Register offsets on the plain register port
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_LOW  = 8'h2A;
	localparam logic [7:0] OFS_HIGH = 8'h2B;
	localparam logic [7:0] OFS_STAT = 8'h30;
	localparam logic [7:0] OFS_LAST = 8'h31;

	// Mode register field positions and reset
	localparam int unsigned MODE_UNICAST_ACCEPT_ENABLE_BIT = 0;
	localparam int unsigned MODE_PROMISCUOUS_ACCEPT_ENABLE_BIT = 1;
	localparam logic [1:0]  MODE_RESET    = 2'h0;

	// Station address reset values; the low word is arbitrary
	localparam logic [31:0] LOW_RESET  = 32'h0300_0002;
	localparam logic [15:0] HIGH_RESET = 16'h0100;

	// Status register field positions
	localparam int unsigned STAT_ACC_LSB = 0;
	localparam int unsigned STAT_REJ_LSB = 16;

	// Last decision register field positions
	localparam int unsigned LAST_ACC_BIT   = 0;
	localparam int unsigned LAST_MATCH_BIT = 1;
	localparam int unsigned LAST_GROUP_BIT = 2;

	// Individual/group bit of address byte 0
	localparam int unsigned GROUP_BIT = 0;

	localparam logic [2:0] IDX_FIRST = 3'h1;
	localparam logic [2:0] IDX_LAST  = 3'h5;

	typedef struct packed {
		logic       valid;
		logic       sof;
		logic [7:0] data;
	} sauf_rx_byte_t;

	typedef struct packed {
		logic valid;
		logic accept;
		logic own_match;
		logic group;
	} sauf_decision_t;

	typedef struct packed {
		logic promiscuous_accept_enable;
		logic unicast_accept_enable;
	} sauf_mode_t;

	typedef enum logic [0:0] {
		SAUF_IDLE,
		SAUF_COLLECT
	} sauf_state_t;
endpackage : sauf_pkg
`default_nettype wire

//--- hw/sauf_lane_match.sv
`default_nettype none
module sauf_lane_match #(
	parameter int unsigned W = 8
) (
	input  wire logic [W-1:0] rx_lane,
	input  wire logic [W-1:0] own_lane,
	output var  logic         lane_eq
);
	assign lane_eq = (rx_lane == own_lane);
endmodule : sauf_lane_match
`default_nettype wire

//--- hw/sauf_filter.sv
`default_nettype none
module sauf_filter (
	input  wire logic                                core_clk,
	input  wire logic                                rst_n,
	input  wire logic [sauf_pkg::ADDR_W-1:0]         reg_addr,
	input  wire logic [sauf_pkg::DATA_W-1:0]         reg_wdata,
	input  wire logic                                reg_wr,
	input  wire logic                                reg_rd,
	output var  logic [sauf_pkg::DATA_W-1:0]         reg_rdata,
	input  wire sauf_pkg::sauf_rx_byte_t             rx_byte,
	output var  sauf_pkg::sauf_decision_t            rx_decision
);
	// Register state
	logic [31:0]                     addr_low_q;
	logic [15:0]                     addr_high_q;
	sauf_pkg::sauf_mode_t            mode_q;
	logic [sauf_pkg::CNT_W-1:0]      acc_cnt_q;
	logic [sauf_pkg::CNT_W-1:0]      rej_cnt_q;
	logic [sauf_pkg::DATA_W-1:0]     rdata_q;
	logic [2:0]                      last_q;

	// Destination collection state
	sauf_pkg::sauf_state_t           state_q;
	sauf_pkg::sauf_state_t           state_d;
	logic [2:0]                      idx_q;
	logic [2:0]                      idx_d;
	logic [47:0]                     dest_q;
	logic [47:0]                     dest_d;
	logic                            cmp_go_q;
	logic                            cmp_go_d;
	sauf_pkg::sauf_decision_t        dec_q;
	sauf_pkg::sauf_decision_t        dec_d;

	// Register decode
	wire wr_mode = reg_wr && (reg_addr == sauf_pkg::OFS_MODE);
	wire wr_low  = reg_wr && (reg_addr == sauf_pkg::OFS_LOW);
	wire wr_high = reg_wr && (reg_addr == sauf_pkg::OFS_HIGH);
	wire wr_stat = reg_wr && (reg_addr == sauf_pkg::OFS_STAT);

	wire [31:0] mode_rd = {30'h0, mode_q.promiscuous_accept_enable, mode_q.unicast_accept_enable};
	wire [31:0] high_rd = {16'h0000, addr_high_q};
	wire [31:0] stat_rd = {rej_cnt_q, acc_cnt_q};
	wire [31:0] last_rd = {29'h0, last_q};

	logic [31:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			sauf_pkg::OFS_MODE: rd_mux = mode_rd;
			sauf_pkg::OFS_LOW:  rd_mux = addr_low_q;
			sauf_pkg::OFS_HIGH: rd_mux = high_rd;
			sauf_pkg::OFS_STAT: rd_mux = stat_rd;
			sauf_pkg::OFS_LAST: rd_mux = last_rd;
			default:            rd_mux = 32'h0000_0000;
		endcase
	end

	// Station address registers; writes land at the clock edge, so any
	// comparison started on a later edge already sees the new address
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_low_q  <= sauf_pkg::LOW_RESET;
			addr_high_q <= sauf_pkg::HIGH_RESET;
		end else begin
			if (wr_low) begin
				addr_low_q <= reg_wdata;
			end
			if (wr_high) begin
				addr_high_q <= reg_wdata[15:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= sauf_pkg::MODE_RESET;
		end else if (wr_mode) begin
			mode_q.unicast_accept_enable <= reg_wdata[sauf_pkg::MODE_UNICAST_ACCEPT_ENABLE_BIT];
			mode_q.promiscuous_accept_enable <= reg_wdata[sauf_pkg::MODE_PROMISCUOUS_ACCEPT_ENABLE_BIT];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	// Byte order on the medium: byte 0 first, stored in bits 7:0
	wire take_first = rx_byte.valid && rx_byte.sof;
	wire take_next  = rx_byte.valid && !rx_byte.sof && (state_q == sauf_pkg::SAUF_COLLECT);
	wire [5:0] lane_sel;

	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_sel
			assign lane_sel[gi] = take_next && (idx_q == 3'(gi));
		end
	endgenerate

	always_comb begin
		state_d  = state_q;
		idx_d    = idx_q;
		dest_d   = dest_q;
		cmp_go_d = 1'b0;
		unique case (state_q)
			sauf_pkg::SAUF_IDLE: begin
				if (take_first) begin
					dest_d[7:0] = rx_byte.data;
					idx_d       = sauf_pkg::IDX_FIRST;
					state_d     = sauf_pkg::SAUF_COLLECT;
				end
			end
			sauf_pkg::SAUF_COLLECT: begin
				// A new start of frame abandons a partial address
				if (take_first) begin
					dest_d[7:0] = rx_byte.data;
					idx_d       = sauf_pkg::IDX_FIRST;
				end else if (take_next) begin
					dest_d[{idx_q, 3'b000} +: 8] = rx_byte.data;
					idx_d                        = idx_q + 3'h1;
					if (idx_q == sauf_pkg::IDX_LAST) begin
						cmp_go_d = 1'b1;
						state_d  = sauf_pkg::SAUF_IDLE;
					end
				end
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q  <= sauf_pkg::SAUF_IDLE;
			idx_q    <= 3'h0;
			dest_q   <= 48'h0000_0000_0000;
			cmp_go_q <= 1'b0;
		end else begin
			state_q  <= state_d;
			idx_q    <= idx_d;
			dest_q   <= dest_d;
			cmp_go_q <= cmp_go_d;
		end
	end

	// Station address as one 48-bit word, byte 0 in the low lane
	wire [47:0] own_addr = {addr_high_q, addr_low_q};
	wire [5:0]  lane_eq;

	generate
		for (gi = 0; gi < 6; gi++) begin : g_lane
			sauf_lane_match #(
				.W (8)
			) u_lane (
				.rx_lane  (dest_q[gi*8 +: 8]),
				.own_lane (own_addr[gi*8 +: 8]),
				.lane_eq  (lane_eq[gi])
			);
		end
	endgenerate

	wire own_match = &lane_eq;
	wire is_group  = dest_q[sauf_pkg::GROUP_BIT];

	// Group frames are passed on as not accepted here unless promiscuous;
	// later filtering decides on them
	wire uc_accept = mode_q.unicast_accept_enable && own_match && !is_group;
	wire accept    = mode_q.promiscuous_accept_enable || uc_accept;

	always_comb begin
		dec_d           = '0;
		dec_d.valid     = cmp_go_q;
		dec_d.accept    = cmp_go_q && accept;
		dec_d.own_match = cmp_go_q && own_match;
		dec_d.group     = cmp_go_q && is_group;
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			dec_q <= '0;
		end else begin
			dec_q <= dec_d;
		end
	end

	// Accept and reject counters; a count in the clearing cycle is kept
	wire [sauf_pkg::CNT_W-1:0] acc_inc = (cmp_go_q && accept) ? 16'h0001 : 16'h0000;
	wire [sauf_pkg::CNT_W-1:0] rej_inc = (cmp_go_q && !accept) ? 16'h0001 : 16'h0000;
	wire                       acc_sat = &acc_cnt_q;
	wire                       rej_sat = &rej_cnt_q;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_cnt_q <= 16'h0000;
			rej_cnt_q <= 16'h0000;
		end else if (wr_stat) begin
			acc_cnt_q <= acc_inc;
			rej_cnt_q <= rej_inc;
		end else begin
			if (!acc_sat) begin
				acc_cnt_q <= acc_cnt_q + acc_inc;
			end
			if (!rej_sat) begin
				rej_cnt_q <= rej_cnt_q + rej_inc;
			end
		end
	end

	// Last decision kept for software
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			last_q <= 3'h0;
		end else if (cmp_go_q) begin
			last_q[sauf_pkg::LAST_ACC_BIT]   <= accept;
			last_q[sauf_pkg::LAST_MATCH_BIT] <= own_match;
			last_q[sauf_pkg::LAST_GROUP_BIT] <= is_group;
		end
	end

	assign reg_rdata   = rdata_q;
	assign rx_decision = dec_q;
endmodule : sauf_filter
`default_nettype wire

//--- testbench/sauf_filter_props.sv
`default_nettype none
module sauf_filter_props (
	input wire logic                     core_clk,
	input wire logic                     rst_n,
	input wire logic [7:0]               reg_addr,
	input wire logic [31:0]              reg_wdata,
	input wire logic                     reg_wr,
	input wire logic                     reg_rd,
	input wire logic [31:0]              reg_rdata,
	input wire sauf_pkg::sauf_rx_byte_t  rx_byte,
	input wire sauf_pkg::sauf_decision_t rx_decision
);
	logic [1:0] mode_q;
	logic       grp_q;
	wire        dv = rx_decision.valid;
	wire        po = mode_q[1];
	wire        uc = mode_q[0];
	// Shadow of the mode word, since the checker only sees the ports
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) mode_q <= '0;
		else if (reg_wr && reg_addr == sauf_pkg::OFS_MODE) mode_q <= reg_wdata[1:0];
	end
	always_ff @(posedge core_clk) begin
		if (rx_byte.valid && rx_byte.sof) grp_q <= rx_byte.data[0];
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_rdata_idle: assert property (
		!$past(reg_rd) |-> reg_rdata == '0) else $error("read data outside read slot");
	a_high_resv: assert property (
		$past(reg_rd) && $past(reg_addr) == sauf_pkg::OFS_HIGH |-> reg_rdata[31:16] == '0)
		else $error("reserved high bits not zero");
	a_low_echo: assert property (
		reg_wr && reg_addr == sauf_pkg::OFS_LOW ##1 reg_rd && reg_addr == sauf_pkg::OFS_LOW
		|=> reg_rdata == $past(reg_wdata, 2)) else $error("low word read back wrong");
	a_dec_late: assert property (
		dv |-> $past(rx_byte.valid, 2) && !$past(rx_byte.sof, 2)) else $error("decision timing");
	a_promisc_acc: assert property (
		dv && po |-> rx_decision.accept) else $error("promiscuous frame rejected");
	a_unicast_off: assert property (
		dv && !uc && !po |-> !rx_decision.accept) else $error("unicast accepted while off");
	a_accept_rule: assert property (
		dv |-> rx_decision.accept == (po || uc && rx_decision.own_match && !rx_decision.group))
		else $error("accept decision wrong");
	a_group_flag: assert property (
		dv |-> rx_decision.group == grp_q) else $error("group flag not from byte 0");
	c_own_acc: cover property (dv && rx_decision.own_match && rx_decision.accept);
	c_own_rej: cover property (dv && rx_decision.own_match && !rx_decision.accept);
	c_high_rd: cover property (reg_rd && reg_addr == sauf_pkg::OFS_HIGH);
endmodule : sauf_filter_props
bind sauf_filter sauf_filter_props sauf_filter_props_i (.core_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_byte, .rx_decision);
`default_nettype wire

//--- testbench/sauf_rx_src.sv
`default_nettype none
module sauf_rx_src (
	input  wire logic                    core_clk,
	output var  sauf_pkg::sauf_rx_byte_t rx_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial rx_byte = '0;
	// Byte 0 leaves first; idle slots show the inverse, never a stale byte
	task automatic send(input logic [47:0] a, input int g);
		for (int i = 0; i < 6; i++) begin
			rx_byte <= '{1'b1, i == 0, a[8*i+:8]};
			@(posedge core_clk);
			// No gap after byte 5, so the caller always resumes just after its edge
			if (i < 5) repeat (g) begin
				rx_byte <= '{1'b0, 1'b0, ~a[8*i+:8]};
				@(posedge core_clk);
			end
		end
		rx_byte <= '{1'b0, 1'b0, ~a[47:40]};
	endtask : send
endmodule : sauf_rx_src
`default_nettype wire

//--- testbench/tb_top.sv
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [1:0] m; logic [47:0] d; logic [3:0] e;} sauf_row_t;
	localparam logic [47:0] STA = 48'h6655_4433_2210;
	localparam logic [31:0] NLO = 32'h7788_9900;
	logic                     core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
	logic [7:0]               reg_addr = '0;
	logic [31:0]              reg_wdata = '0, reg_rdata;
	sauf_pkg::sauf_rx_byte_t  rx_byte;
	sauf_pkg::sauf_decision_t rx_decision;
	int                       num_errors = 0, n_tests = 0;
	// Mode, destination, expected {valid, accept, own, group}
	sauf_row_t rows [7] = '{'{2'h1, STA, 4'hE}, '{2'h1, STA ^ 48'h0100_0000_0000, 4'h8},
		'{2'h0, STA, 4'hA}, '{2'h2, 48'h0000_0000_1234, 4'hC}, '{2'h1, STA | 48'h1, 4'h9},
		'{2'h3, STA | 48'h1, 4'hD}, '{2'h1, 48'h6655_4433_1022, 4'h8}};
	always #12.5 core_clk = ~core_clk;
	sauf_filter sauf_filter_i (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rx_byte, .rx_decision);
	sauf_rx_src sauf_rx_src_i (.core_clk, .rx_byte);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// Tasks start just after a rising edge and end just after one
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr <= 1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_rd <= 1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 0;
		@(negedge core_clk) chk(reg_rdata, e);
		@(posedge core_clk);
	endtask : rd
	task automatic fr(input logic [47:0] d, input int g, input logic [3:0] e);
		sauf_rx_src_i.send(d, g);
		// Byte 5 was taken at the last edge; decision stands just after the next edge
		@(posedge core_clk);
		@(negedge core_clk) chk(32'(rx_decision), 32'(e));
		@(posedge core_clk);
	endtask : fr
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	initial begin
		repeat (4000) @(posedge core_clk);
		num_errors++;
		end_sim();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1;
		@(posedge core_clk);
		rd(sauf_pkg::OFS_LOW, sauf_pkg::LOW_RESET);
		rd(sauf_pkg::OFS_HIGH, 32'h0000_0100);
		wr(sauf_pkg::OFS_LOW, STA[31:0]);
		rd(sauf_pkg::OFS_LOW, STA[31:0]);
		wr(sauf_pkg::OFS_HIGH, {16'hFFFF, STA[47:32]});
		rd(sauf_pkg::OFS_HIGH, {16'h0000, STA[47:32]});
		foreach (rows[i]) begin
			wr(sauf_pkg::OFS_MODE, 32'(rows[i].m));
			fr(rows[i].d, i % 2, rows[i].e);
			$display("row %0d done", i);
		end
		// Write lands on the same edge as byte 0, before the compare cycle
		fork
			fr({STA[47:32], NLO}, 0, 4'hE);
			wr(sauf_pkg::OFS_LOW, NLO);
		join
		rd(sauf_pkg::OFS_LAST, 32'h0000_0003);
		rd(sauf_pkg::OFS_STAT, 32'h0004_0004);
		rd(8'h7F, 32'h0000_0000);
		wr(8'h7F, 32'hFFFF_FFFF);
		rd(sauf_pkg::OFS_LOW, NLO);
		$display("late write and unmapped done");
		rst_n <= 0;
		@(posedge core_clk);
		rst_n <= 1;
		@(posedge core_clk);
		rd(sauf_pkg::OFS_HIGH, 32'h0000_0100);
		rd(sauf_pkg::OFS_LOW, sauf_pkg::LOW_RESET);
		$display("second reset done");
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
